/* hw/addr_decode_pkg.sv */
// Purpose: shared constants and types for the local bus address decoder
// Assumes: 32-bit local addresses, 3-bit function code
// Notes:   region codes are one-hot target selects, except scsi, which also sets the channel controller select
package addr_decode_pkg;

  // function code spaces
  localparam logic [2:0] FC_USER_DATA  = 3'h1;
  localparam logic [2:0] FC_USER_PROG  = 3'h2;
  localparam logic [2:0] FC_SUPV_DATA  = 3'h5;
  localparam logic [2:0] FC_SUPV_PROG  = 3'h6;

  // main map boundaries
  localparam logic [31:0] VME_A24_BASE   = 32'hF0000000;
  localparam logic [31:0] VME_A32_BASE   = 32'hF1000000;
  localparam logic [31:0] ROM1_BASE      = 32'hFF800000;
  localparam logic [31:0] ROM2_BASE      = 32'hFFA00000;
  localparam logic [31:0] UPPER_RSV_BASE = 32'hFFC00000;
  localparam logic [31:0] LOCAL_IO_BASE  = 32'hFFFE0000;
  localparam logic [31:0] IO_RSV_BASE    = 32'hFFFE5000;
  localparam logic [31:0] SHORT_IO_BASE  = 32'hFFFF0000;

  // local I/O sub-blocks, selected by address bits 14:11 (2KB blocks)
  localparam logic [3:0] IO_BBRAM_LO = 4'h0;
  localparam logic [3:0] IO_BBRAM_HI = 4'h1;
  localparam logic [3:0] IO_PCC      = 4'h2;
  localparam logic [3:0] IO_LAN      = 4'h3;
  localparam logic [3:0] IO_VMECTL   = 4'h4;
  localparam logic [3:0] IO_PRINTER  = 4'h5;
  localparam logic [3:0] IO_SERIAL1  = 4'h6;
  localparam logic [3:0] IO_SERIAL2  = 4'h7;
  localparam logic [3:0] IO_SCSI_LO  = 4'h8;
  localparam logic [3:0] IO_SCSI_HI  = 4'h9;

  // memory size limits in bytes
  localparam logic [31:0] MEM_SIZE_MIN = 32'h00400000;
  localparam logic [31:0] MEM_SIZE_MAX = 32'h02000000;

  // bus cycles after reset that alias boot ROM at zero
  localparam int          BOOT_ALIAS_CYCLES = 4;
  localparam logic [2:0]  BOOT_ALIAS_CNT    = 3'h4;

  // port width codes
  localparam logic [1:0] WIDTH_NONE = 2'h0;
  localparam logic [1:0] WIDTH_8    = 2'h1;
  localparam logic [1:0] WIDTH_16   = 2'h2;
  localparam logic [1:0] WIDTH_32   = 2'h3;

  // target selects, one-hot except scsi, which also sets peripheral_channel_controller
  typedef struct packed {
    logic dram;
    logic vme_a32a24;
    logic vme_a24;
    logic vme_a32;
    logic rom1;
    logic rom2;
    logic bbram_clock;
    logic peripheral_channel_controller;
    logic lan;
    logic vme_ctl;
    logic prn_data;
    logic prn_status;
    logic serial1_b;
    logic serial1_a;
    logic serial2_b;
    logic serial2_a;
    logic scsi;
  } target_sel_t;

  // access request from the processor
  typedef struct packed {
    logic        start;
    logic        write;
    logic [2:0]  function_code;
    logic [31:0] addr;
  } bus_req_t;

  // decode answer
  typedef struct packed {
    target_sel_t sel;
    logic [1:0]  port_width;
    logic        cache_inhibit;
    logic        timeout;
    logic [31:0] local_addr;
  } decode_t;

endpackage

/* hw/local_bus_address_decoder.sv */
// Purpose: decode processor program/data accesses into one-hot target selects (scsi also sets the channel controller select)
// Assumes: one request pulse per bus cycle, same clock as the processor bus logic
// Notes:   answer is registered one cycle after the request pulse
`timescale 1ns/1ps
`default_nettype none

module local_bus_address_decoder #(
  parameter logic [31:0] INSTALLED_MEMORY_SIZE = 32'h00400000,
  parameter bit          LAN_FITTED            = 1'b1
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire addr_decode_pkg::bus_req_t  req,
  output var  addr_decode_pkg::decode_t   dec,
  output logic                            dec_valid,
  output logic                            boot_alias
);

  // the memory size must be a power of two within the supported span
  if (INSTALLED_MEMORY_SIZE < addr_decode_pkg::MEM_SIZE_MIN ||
      INSTALLED_MEMORY_SIZE > addr_decode_pkg::MEM_SIZE_MAX ||
      (INSTALLED_MEMORY_SIZE & (INSTALLED_MEMORY_SIZE - 32'h1)) != 32'h0)
  begin : g_bad_mem_size
    $error("installed memory size out of range");
  end

  logic [2:0]                  boot_cnt_ff;
  logic [2:0]                  nxt_boot_cnt;
  addr_decode_pkg::decode_t    dec_ff;
  addr_decode_pkg::decode_t    nxt_dec;
  logic                        valid_ff;

  // cycle counter for the reset-time ROM alias
  assign boot_alias   = boot_cnt_ff < addr_decode_pkg::BOOT_ALIAS_CNT;
  assign nxt_boot_cnt = (req.start && boot_alias) ? boot_cnt_ff + 3'h1 : boot_cnt_ff;

  // space and range qualification
  wire [31:0] a = req.addr;
  wire fc_ok = req.function_code == addr_decode_pkg::FC_USER_DATA ||
               req.function_code == addr_decode_pkg::FC_USER_PROG ||
               req.function_code == addr_decode_pkg::FC_SUPV_DATA ||
               req.function_code == addr_decode_pkg::FC_SUPV_PROG;
  wire in_dram     = a < INSTALLED_MEMORY_SIZE;
  wire in_vme_low  = !in_dram && a < addr_decode_pkg::VME_A24_BASE;
  wire in_vme_a24  = a >= addr_decode_pkg::VME_A24_BASE && a < addr_decode_pkg::VME_A32_BASE;
  wire in_vme_a32  = a >= addr_decode_pkg::VME_A32_BASE && a < addr_decode_pkg::ROM1_BASE;
  wire in_rom1     = a >= addr_decode_pkg::ROM1_BASE && a < addr_decode_pkg::ROM2_BASE;
  wire in_rom2     = a >= addr_decode_pkg::ROM2_BASE && a < addr_decode_pkg::UPPER_RSV_BASE;
  wire in_local_io = a >= addr_decode_pkg::LOCAL_IO_BASE && a < addr_decode_pkg::IO_RSV_BASE;
  wire in_short_io = a >= addr_decode_pkg::SHORT_IO_BASE;

  // local I/O block select, 2KB granules
  wire [3:0] io_blk   = a[14:11];
  wire       io_bbram = in_local_io && (io_blk == addr_decode_pkg::IO_BBRAM_LO ||
                                        io_blk == addr_decode_pkg::IO_BBRAM_HI);
  wire       io_pcc   = in_local_io && io_blk == addr_decode_pkg::IO_PCC;
  wire       io_lan   = in_local_io && io_blk == addr_decode_pkg::IO_LAN && LAN_FITTED;
  wire       io_vme   = in_local_io && io_blk == addr_decode_pkg::IO_VMECTL;
  wire       io_prn   = in_local_io && io_blk == addr_decode_pkg::IO_PRINTER;
  wire       io_ser1  = in_local_io && io_blk == addr_decode_pkg::IO_SERIAL1;
  wire       io_ser2  = in_local_io && io_blk == addr_decode_pkg::IO_SERIAL2;
  wire       io_scsi  = in_local_io && (io_blk == addr_decode_pkg::IO_SCSI_LO ||
                                        io_blk == addr_decode_pkg::IO_SCSI_HI);

  // target selects; repeated images fold onto the low address bits
  addr_decode_pkg::target_sel_t sel;
  always_comb
  begin
    sel = '0;
    if (fc_ok)
    begin
      sel.dram        = in_dram && !boot_alias;
      sel.rom1        = in_rom1 || (in_dram && boot_alias);
      sel.vme_a32a24  = in_vme_low;
      sel.vme_a24     = in_vme_a24;
      sel.vme_a32     = in_vme_a32 || in_short_io;
      sel.rom2        = in_rom2;
      sel.bbram_clock = io_bbram;
      sel.peripheral_channel_controller         = io_pcc || io_scsi;
      sel.lan         = io_lan;
      sel.vme_ctl     = io_vme;
      sel.prn_data    = io_prn && req.write;
      sel.prn_status  = io_prn && !req.write;
      sel.serial1_b   = io_ser1 && !a[1];
      sel.serial1_a   = io_ser1 && a[1];
      sel.serial2_b   = io_ser2 && !a[1];
      sel.serial2_a   = io_ser2 && a[1];
      sel.scsi        = io_scsi;
    end
  end

  // width, cache-inhibit and time-out
  wire any_sel = |sel;
  wire is_w16  = sel.rom1 || sel.rom2 || sel.vme_a24 || sel.vme_a32 || sel.lan || sel.vme_ctl;
  wire is_w8   = sel.bbram_clock || sel.prn_data || sel.prn_status ||
                 sel.serial1_a || sel.serial1_b || sel.serial2_a || sel.serial2_b || sel.scsi;
  wire is_w32  = sel.dram || sel.vme_a32a24 || (sel.peripheral_channel_controller && !sel.scsi && !a[4] && !a[5]);

  always_comb
  begin
    nxt_dec               = '0;
    nxt_dec.sel           = sel;
    nxt_dec.timeout       = !any_sel;
    nxt_dec.cache_inhibit = any_sel && !sel.dram;
    nxt_dec.port_width    = is_w32 ? addr_decode_pkg::WIDTH_32 :
                            is_w8  ? addr_decode_pkg::WIDTH_8 :
                            (is_w16 || sel.peripheral_channel_controller) ? addr_decode_pkg::WIDTH_16 :
                            addr_decode_pkg::WIDTH_NONE;
    // mirrors fold: bbram/clock 2KB, serial and scsi 2B with only a[0] kept
    nxt_dec.local_addr    = sel.bbram_clock ? {21'h0, a[10:0]} :
                            sel.scsi        ? {31'h0, a[0]} :
                            (sel.serial1_a || sel.serial1_b ||
                             sel.serial2_a || sel.serial2_b) ? {31'h0, a[0]} :
                            sel.peripheral_channel_controller         ? {26'h0, a[5:0]} :
                            a;
  end

  // registered answer
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      boot_cnt_ff <= 3'h0;
      dec_ff      <= '0;
      valid_ff    <= 1'b0;
    end
    else
    begin
      boot_cnt_ff <= nxt_boot_cnt;
      dec_ff      <= req.start ? nxt_dec : dec_ff;
      valid_ff    <= req.start;
    end
  end

  assign dec       = dec_ff;
  assign dec_valid = valid_ff;

endmodule
`default_nettype wire

/* tb/cpu_core_model.sv */
// Purpose: processor core model issuing local bus cycles
// Assumes: bench raises go for exactly one clock per bus cycle
// Notes:   address lines show the inverse value while idle
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input  wire logic                      go,
  input  wire logic                      wr,
  input  wire logic [2:0]                fc,
  input  wire logic [31:0]               addr,
  output var  addr_decode_pkg::bus_req_t req
);
  // idle bus never repeats the last address, so stale decode shows up
  assign req = '{go, wr, fc, go ? addr : ~addr};
endmodule
`default_nettype wire

/* tb/local_bus_address_decoder_chk.sv */
// Purpose: port-level checks of the address decoder
// Assumes: answer one cycle after each start pulse
// Notes:   bound to every decoder instance
`timescale 1ns/1ps
`default_nettype none
module local_bus_address_decoder_chk #(
  parameter logic [31:0] INSTALLED_MEMORY_SIZE = 32'h00400000,
  parameter bit          LAN_FITTED            = 1'b1
) (
  input wire logic                      sys_clk,
  input wire logic                      rst,
  input wire addr_decode_pkg::bus_req_t req,
  input wire addr_decode_pkg::decode_t  dec,
  input wire logic                      dec_valid,
  input wire logic                      boot_alias
);
  logic ok;
  logic st;
  // decoded spaces and a start in one of them
  assign ok = req.function_code inside {3'h1, 3'h2, 3'h5, 3'h6};
  assign st = req.start && ok;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_valid_pulse: assert property (req.start |=> dec_valid) else $error("no answer");
  a_fc_reserved: assert property (req.start && !ok |=> dec.timeout && dec.sel == '0)
    else $error("reserved space decoded");
  a_boot_rom: assert property (st && boot_alias && req.addr < INSTALLED_MEMORY_SIZE
    |=> dec.sel.rom1 && !dec.sel.dram) else $error("boot alias missed");
  a_dram_after: assert property (st && !boot_alias && req.addr < INSTALLED_MEMORY_SIZE
    |=> dec.sel.dram) else $error("dram not selected");
  a_vme_above: assert property (st && req.addr >= INSTALLED_MEMORY_SIZE
    && req.addr < 32'hF0000000 |=> dec.sel.vme_a32a24) else $error("vme window missed");
  a_dram_fast: assert property (dec_valid && dec.sel.dram
    |-> !dec.cache_inhibit && dec.port_width == 2'h3) else $error("dram attributes");
  a_prn_write: assert property (st && req.write && req.addr == 32'hFFFE2800
    |=> dec.sel.prn_data && !dec.sel.prn_status) else $error("printer write");
  a_prn_read: assert property (st && !req.write && req.addr == 32'hFFFE2800
    |=> dec.sel.prn_status && !dec.sel.prn_data) else $error("printer read");
  a_io_reserved: assert property (st && req.addr inside {[32'hFFFE5000:32'hFFFEFFFF]}
    |=> dec.timeout && dec.sel == '0) else $error("reserved range claimed");
  a_lan_absent: assert property (st && !LAN_FITTED
    && req.addr inside {[32'hFFFE1800:32'hFFFE1FFF]} |=> dec.timeout) else $error("lan claimed");
endmodule
bind local_bus_address_decoder local_bus_address_decoder_chk #(
  .INSTALLED_MEMORY_SIZE(INSTALLED_MEMORY_SIZE), .LAN_FITTED(LAN_FITTED)) i_chk (
  .sys_clk(sys_clk), .rst(rst), .req(req), .dec(dec), .dec_valid(dec_valid),
  .boot_alias(boot_alias));
`default_nettype wire

/* tb/tb.sv */
// Purpose: self-checking bench for the address decoder
// Assumes: 8MB installed memory; a second decoder without LAN
// Notes:   each access waits a bounded time for the answer pulse
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [31:0] MEM = 32'h00800000;
  logic                      sys_clk = 1'b0;
  logic                      rst = 1'b1;
  logic                      go = 1'b0;
  logic                      wr = 1'b0;
  logic [2:0]                fc = 3'h5;
  logic [31:0]               addr = 32'h0;
  addr_decode_pkg::bus_req_t req;
  addr_decode_pkg::decode_t  dec;
  addr_decode_pkg::decode_t  dec_nl;
  logic                      dec_valid;
  logic                      boot_alias;
  int                        err_count = 0;
  int                        total_checks = 0;
  cpu_core_model i_cpu_core_model (.go(go), .wr(wr), .fc(fc), .addr(addr), .req(req));
  local_bus_address_decoder #(.INSTALLED_MEMORY_SIZE(MEM)) i_local_bus_address_decoder (
    .sys_clk(sys_clk), .rst(rst), .req(req), .dec(dec), .dec_valid(dec_valid),
    .boot_alias(boot_alias));
  local_bus_address_decoder #(.INSTALLED_MEMORY_SIZE(MEM), .LAN_FITTED(1'b0))
    i_local_bus_address_decoder_nolan (.sys_clk(sys_clk), .rst(rst), .req(req),
    .dec(dec_nl), .dec_valid(), .boot_alias());
  // 200 MHz clock
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input string name, input logic [20:0] exp, input logic [20:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic cmp_addr(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask
  // one bus cycle, then the expected select, width, inhibit and timeout
  task automatic hit(input logic w, input logic [2:0] f, input logic [31:0] a,
                     input logic [16:0] s, input logic [1:0] pw);
    int i;
    @(posedge sys_clk) #1;
    {go, wr, fc, addr} = {1'b1, w, f, a};
    @(posedge sys_clk) #1;
    go = 1'b0;
    for (i = 0; i < 4 && dec_valid !== 1'b1; i++) @(posedge sys_clk) #1;
    if (dec_valid !== 1'b1)
    begin
      err_count++;
      test_done();
    end
    cmp("decode", {s, pw, s != 17'h0 && !s[16], s == 17'h0},
        {dec.sel, dec.port_width, dec.cache_inhibit, dec.timeout});
  endtask
  task automatic t_boot;
    hit(1'b0, 3'h0, 32'h0, 17'h0, 2'h0);
    hit(1'b1, 3'h3, 32'h0, 17'h0, 2'h0);
    hit(1'b0, 3'h4, 32'h0, 17'h0, 2'h0);
    cmp("alias", 21'h1, {20'h0, boot_alias});
    hit(1'b0, 3'h5, 32'h0, 17'h01000, 2'h2);
    cmp("alias", 21'h0, {20'h0, boot_alias});
    hit(1'b0, 3'h5, 32'h0, 17'h10000, 2'h3);
  endtask
  task automatic t_main_map;
    hit(1'b1, 3'h1, MEM - 32'h1, 17'h10000, 2'h3);
    hit(1'b0, 3'h2, MEM, 17'h08000, 2'h3);
    hit(1'b0, 3'h6, 32'hF0FFFFFF, 17'h04000, 2'h2);
    hit(1'b0, 3'h1, 32'hF1000000, 17'h02000, 2'h2);
    hit(1'b0, 3'h5, 32'hFF9FFFFF, 17'h01000, 2'h2);
    hit(1'b0, 3'h2, 32'hFFA00000, 17'h00800, 2'h2);
    hit(1'b1, 3'h6, 32'hFFFF0000, 17'h02000, 2'h2);
  endtask
  task automatic t_local_io;
    hit(1'b0, 3'h5, 32'hFFFE07F8, 17'h00400, 2'h1);
    hit(1'b1, 3'h5, 32'hFFFE0FFF, 17'h00400, 2'h1);
    cmp_addr("bbram image", 32'h000007FF, dec.local_addr);
    hit(1'b0, 3'h5, 32'hFFFE1000, 17'h00200, 2'h3);
    hit(1'b1, 3'h5, 32'hFFFE1010, 17'h00200, 2'h2);
    hit(1'b0, 3'h5, 32'hFFFE2000, 17'h00080, 2'h2);
    hit(1'b1, 3'h5, 32'hFFFE2800, 17'h00040, 2'h1);
    hit(1'b0, 3'h5, 32'hFFFE2800, 17'h00020, 2'h1);
    hit(1'b0, 3'h1, 32'hFFFE3000, 17'h00010, 2'h1);
    hit(1'b0, 3'h1, 32'hFFFE3003, 17'h00008, 2'h1);
    hit(1'b1, 3'h2, 32'hFFFE3801, 17'h00004, 2'h1);
    hit(1'b1, 3'h2, 32'hFFFE3802, 17'h00002, 2'h1);
    hit(1'b0, 3'h6, 32'hFFFE4001, 17'h00201, 2'h1);
    cmp_addr("scsi data", 32'h00000001, dec.local_addr);
    hit(1'b0, 3'h5, 32'hFFFE1803, 17'h00100, 2'h2);
    cmp("no lan timeout", 21'h1, {20'h0, dec_nl.timeout});
  endtask
  task automatic t_reserved;
    hit(1'b0, 3'h5, 32'hFFC00000, 17'h0, 2'h0);
    hit(1'b1, 3'h5, 32'hFFFDFFFF, 17'h0, 2'h0);
    hit(1'b0, 3'h1, 32'hFFFE5000, 17'h0, 2'h0);
    hit(1'b0, 3'h7, 32'hFFFE4000, 17'h0, 2'h0);
  endtask
  // reset for two clocks, then the scenarios
  initial
  begin
    repeat (2) @(posedge sys_clk);
    #1 rst = 1'b0;
    t_boot();
    t_main_map();
    t_local_io();
    t_reserved();
    test_done();
  end
endmodule
`default_nettype wire
